// File: inc/utx_brg_if.sv
// Interface between the transmitter and its baud rate generator.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
`default_nettype none

interface utx_brg_if;
    logic [utx_pkg::DIV_W-1:0] divisor;   // Bit period in system clocks.
    logic                      restart;   // Realign the bit timing.
    logic                      tick;      // One-cycle pulse per bit period.

    modport gen  (input divisor, input restart, output tick);
    modport user (output divisor, output restart, input tick);
endinterface : utx_brg_if

`default_nettype wire

// File: inc/utx_pkg.sv
// Package for the serial transmitter with driver enable.
// Assumes one system clock and a synchronous, active-high reset.

package utx_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_BITS   = 8;
    localparam int DIV_W       = 16;
    localparam int BITCNT_W    = 4;

    // ****************************************************************
    // Timing, in serial bit periods and system clocks
    // ****************************************************************
    // Driver enable leads the start bit by one bit period plus two system clocks.
    localparam int LEAD_BIT_PERIODS = 1;
    // Driver enable trails the last stop bit by this many system clocks.
    localparam int DE_TAIL_CYCLES   = 1;
    // A divisor of zero is treated as this value.
    localparam logic [DIV_W-1:0] DIV_MIN = 16'h0001;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic RST_TXD        = 1'b1;
    localparam logic RST_EMPTY      = 1'b1;
    localparam logic RST_DRV_EN     = 1'b0;
    localparam logic [DIV_W-1:0] RST_DIV_CNT = 16'h0000;

    // ****************************************************************
    // Transmitter states, Gray coded along the frame
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LEAD  = 3'h1,
        ST_START = 3'h3,
        ST_DATA  = 3'h2,
        ST_EXTRA = 3'h6,
        ST_STOP  = 3'h7,
        ST_TAIL  = 3'h5
    } utx_state_t;

endpackage : utx_pkg

// File: sim/tb_utx_top.sv
// Self-checking testbench for the serial transmitter top level.
// Assumes the bound checker and the remote receiver model.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
        $display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
        error_cnt++; \
    end

module tb_utx_top;
    logic        CLK, SRST, TX_WRITE, TX_ENABLE, SERIAL_ENABLE, MULTIPROC_MODE_SELECT;
    logic        ADDR_MARKER_TX_BIT, PARITY_ENABLE, PARITY_ODD, STOP_BITS_TWO, CTS_N;
    logic        CLEAR_TO_SEND_ENABLE, DRV_EN_POLARITY, RX_BYTE_DONE, RX_IS_ADDR;
    logic        RX_ADDR_MATCH, TXD, DRV_EN_OUT, TX_REG_EMPTY, TX_IRQ, RX_IRQ;
    logic        NEW_FRAME_FLAG, TIMER_IRQ, hold, de_act, de_q;
    logic [7:0]  TX_DATA, BAUD_HIGH, BAUD_LOW;
    logic [3:0]  nbits;
    logic [11:0] frm;
    int          error_cnt = 0, checks_done = 0, rx_cnt, c0, d0, f0, i0, r0, t0;
    int          de_cyc = 0, de_fall = 0, txirq = 0, rxirq = 0, tmirq = 0;

    utx_top dut_u
    (
        .CLK, .SRST, .TX_DATA, .TX_WRITE, .TX_ENABLE, .SERIAL_ENABLE,
        .MULTIPROC_MODE_SELECT, .ADDR_MARKER_TX_BIT, .PARITY_ENABLE, .PARITY_ODD,
        .STOP_BITS_TWO, .CLEAR_TO_SEND_ENABLE, .CTS_N, .DRV_EN_POLARITY, .BAUD_HIGH,
        .BAUD_LOW, .RX_BYTE_DONE, .RX_IS_ADDR, .RX_ADDR_MATCH, .TXD, .DRV_EN_OUT,
        .TX_REG_EMPTY, .TX_IRQ, .RX_IRQ, .NEW_FRAME_FLAG, .TIMER_IRQ
    );

    utx_rx_model far_u
    (
        .clk(CLK), .txd(TXD), .div({BAUD_HIGH, BAUD_LOW}), .nbits(nbits), .hold(hold),
        .cts_n(CTS_N), .frm(frm), .cnt(rx_cnt)
    );

    // ********
    // Clock, event counters and helpers
    // ********
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Tests compare how far these counters move across one step.
    assign de_act = DRV_EN_OUT ^ DRV_EN_POLARITY;
    always @(posedge CLK)
    begin
        if (!SRST)
        begin
            de_cyc  += int'(de_act);
            de_fall += int'(de_q && !de_act);
            txirq   += int'(TX_IRQ);
            rxirq   += int'(RX_IRQ);
            tmirq   += int'(TIMER_IRQ);
        end
        de_q = de_act;
    end

    task automatic arm(input int nb);
        nbits = 4'(nb);
        c0 = rx_cnt;
        d0 = de_cyc;
        f0 = de_fall;
        i0 = txirq;
    endtask

    // Writes one byte a clock after the holding register is seen free, then checks it is taken.
    task automatic send(input logic [7:0] d, input logic mk);
        int n = 0;
        do
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        while (TX_REG_EMPTY !== 1'b1 && n < 300);
        @(posedge CLK);
        TX_DATA            <= d;
        ADDR_MARKER_TX_BIT <= mk;
        TX_WRITE           <= 1'b1;
        @(posedge CLK);
        TX_WRITE <= 1'b0;
        @(posedge CLK);
        #1;
        `CHK("empty flag", 1'b0, TX_REG_EMPTY)
    endtask

    // Waits for n characters and the end of the enable, then checks the last frame and the counters.
    task automatic expect_chr(input logic [7:0] d, input logic ext, input logic x, input int n);
        logic [11:0] e;
        logic [11:0] m;
        int          k = 0;
        int          dv = int'({BAUD_HIGH, BAUD_LOW});
        e      = 12'hfff;
        e[7:0] = d;
        e[8]   = ext ? x : 1'b1;
        m      = (12'h001 << nbits) - 12'h001;
        while ((rx_cnt != c0 + n || de_q) && k < 2000)
        begin
            @(posedge CLK);
            #1;
            k++;
        end
        `CHK("frame", e & m, frm & m)
        `CHK("de cycles", dv + 3 + n * (1 + int'(nbits)) * dv, de_cyc - d0)
        `CHK("de falls", 1, de_fall - f0)
        `CHK("tx irqs", n, txirq - i0)
    endtask

    task automatic held();
        repeat (30) @(posedge CLK);
        #1;
        `CHK("de while held", d0, de_cyc)
        `CHK("line while held", 1'b1, TXD)
    endtask

    task automatic rxb(input logic a, input logic mt);
        @(posedge CLK);
        RX_BYTE_DONE  <= 1'b1;
        RX_IS_ADDR    <= a;
        RX_ADDR_MATCH <= mt;
        @(posedge CLK);
        RX_BYTE_DONE <= 1'b0;
        @(posedge CLK);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Generous bound; the tests need under two thousand cycles.
    initial
    begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        tally_and_finish();
    end

    // ********
    // Test sequence
    // ********
    initial
    begin
        {TX_WRITE, ADDR_MARKER_TX_BIT, MULTIPROC_MODE_SELECT, PARITY_ENABLE, PARITY_ODD,
         STOP_BITS_TWO, CLEAR_TO_SEND_ENABLE, DRV_EN_POLARITY, RX_BYTE_DONE, RX_IS_ADDR,
         RX_ADDR_MATCH, hold, BAUD_HIGH, TX_DATA} = '0;
        {SRST, TX_ENABLE, SERIAL_ENABLE} = 3'h7;
        BAUD_LOW = 8'h04;
        nbits = 4'h9;
        repeat (3) @(posedge CLK);
        SRST <= 1'b0;
        arm(9);
        send(8'ha5, 1'b0);
        expect_chr(8'ha5, 1'b0, 1'b0, 1);
        // Parity is left on so the marker must win in 9-bit mode.
        @(posedge CLK);
        MULTIPROC_MODE_SELECT <= 1'b1;
        PARITY_ENABLE         <= 1'b1;
        for (int a = 1; a >= 0; a--)
        begin
            arm(10);
            send(8'h3c, a[0]);
            expect_chr(8'h3c, 1'b1, a[0], 1);
        end
        for (int o = 0; o < 2; o++)
        begin
            @(posedge CLK);
            MULTIPROC_MODE_SELECT <= 1'b0;
            PARITY_ODD            <= o[0];
            arm(10);
            send(8'h07, 1'b1);
            expect_chr(8'h07, 1'b1, ^8'h07 ^ o[0], 1);
        end
        @(posedge CLK);
        PARITY_ENABLE <= 1'b0;
        STOP_BITS_TWO <= 1'b1;
        arm(10);
        send(8'h5a, 1'b0);
        send(8'h5a, 1'b0);
        expect_chr(8'h5a, 1'b0, 1'b0, 2);
        $display("test framing done");
        // Clear-to-send, then transmit enable, each hold a character back.
        for (int b = 0; b < 3; b++)
        begin
            @(posedge CLK);
            STOP_BITS_TWO        <= 1'b0;
            CLEAR_TO_SEND_ENABLE <= (b == 0);
            hold                 <= (b != 1);
            TX_ENABLE            <= (b != 1);
            arm(9);
            send(8'h96, b[0]);
            if (b < 2)
                held();
            @(posedge CLK);
            hold      <= 1'b0;
            TX_ENABLE <= 1'b1;
            expect_chr(8'h96, 1'b0, 1'b0, 1);
        end
        @(posedge CLK);
        DRV_EN_POLARITY <= 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        `CHK("idle de level", 1'b1, DRV_EN_OUT)
        arm(9);
        send(8'hc3, 1'b0);
        expect_chr(8'hc3, 1'b0, 1'b0, 1);
        @(posedge CLK);
        DRV_EN_POLARITY <= 1'b0;
        $display("test gating and polarity done");
        // Address bytes open or close a frame without an interrupt.
        r0 = rxirq;
        i0 = txirq;
        rxb(1'b1, 1'b1);
        `CHK("irq on address", r0, rxirq)
        rxb(1'b0, 1'b0);
        `CHK("first data flag", 1'b1, NEW_FRAME_FLAG)
        rxb(1'b0, 1'b0);
        `CHK("next data flag", 1'b0, NEW_FRAME_FLAG)
        rxb(1'b1, 1'b0);
        rxb(1'b0, 1'b0);
        `CHK("receive irqs", r0 + 2, rxirq)
        `CHK("tx irqs from rx", i0, txirq)
        $display("test receive filter done");
        @(posedge CLK);
        SERIAL_ENABLE <= 1'b0;
        BAUD_LOW      <= 8'h06;
        repeat (12) @(posedge CLK);
        #1;
        t0 = tmirq;
        repeat (60) @(posedge CLK);
        #1;
        `CHK("timer pulses", t0 + 10, tmirq)
        $display("test timer done");
        tally_and_finish();
    end
endmodule // tb_utx_top

`default_nettype wire

// File: sim/utx_rx_model.sv
// Remote serial receiver that samples each character in mid-bit.
// Assumes the bench gives it the bit period and the bits after the start.
`timescale 1ns/1ns
`default_nettype none

module utx_rx_model
(
    input  wire logic        clk,
    input  wire logic        txd,
    input  wire logic [15:0] div,
    input  wire logic [3:0]  nbits,
    input  wire logic        hold,
    output logic             cts_n,
    output logic [11:0]      frm,
    output int               cnt
);
    logic [11:0] shf;

    // The receiver holds the sender off while it is not ready.
    assign cts_n = hold;

    // Fixed mid-bit sampling; simple, but it would not notice a slow drift.
    initial
    begin
        cnt = 0;
        frm = 12'h000;
        forever
        begin
            @(negedge txd);
            repeat (div / 2) @(posedge clk);
            shf = 12'hfff;
            for (int i = 0; i < int'(nbits); i++)
            begin
                repeat (div) @(posedge clk);
                shf[i] = txd;
            end
            frm = shf;
            cnt++;
        end
    end
endmodule // utx_rx_model

`default_nettype wire

// File: sim/utx_top_chk.sv
// Checker for the serial transmitter top level.
// Assumes it is bound to utx_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module utx_top_chk
(
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic       TX_WRITE,
    input wire logic       TX_ENABLE,
    input wire logic       SERIAL_ENABLE,
    input wire logic       CLEAR_TO_SEND_ENABLE,
    input wire logic       CTS_N,
    input wire logic       DRV_EN_POLARITY,
    input wire logic [7:0] BAUD_HIGH,
    input wire logic [7:0] BAUD_LOW,
    input wire logic       RX_BYTE_DONE,
    input wire logic       RX_IS_ADDR,
    input wire logic       TXD,
    input wire logic       DRV_EN_OUT,
    input wire logic       TX_REG_EMPTY,
    input wire logic       TX_IRQ,
    input wire logic       RX_IRQ,
    input wire logic       TIMER_IRQ
);
    // ********
    // Helper logic
    // ********
    logic        de_act;
    logic        blocked;
    logic [15:0] div;
    logic [16:0] lead;
    logic        seen;

    // Polarity is folded out so every check reads the enable as active high.
    assign de_act  = DRV_EN_OUT ^ DRV_EN_POLARITY;
    assign blocked = !SERIAL_ENABLE || !TX_ENABLE || (CLEAR_TO_SEND_ENABLE && CTS_N);
    assign div     = ({BAUD_HIGH, BAUD_LOW} == 16'h0000) ? 16'h0001 : {BAUD_HIGH, BAUD_LOW};

    // Counts enable cycles before the first start bit of a burst.
    always_ff @(posedge CLK)
    begin
        if (SRST || !de_act)
        begin
            lead <= 17'h00000;
            seen <= 1'b0;
        end
        else
        begin
            lead <= seen ? lead : lead + 17'h00001;
            seen <= seen | !TXD;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_drop;
        de_act ##1 !de_act;
    endsequence

    sequence s_held;
        (blocked && !de_act)[*3];
    endsequence

    AST_WRITE_EMPTY: assert property (TX_WRITE && TX_REG_EMPTY |-> ##[1:2] !TX_REG_EMPTY)
        else $error("empty flag stayed high after a write");
    AST_TXIRQ_START: assert property (TX_IRQ |-> TX_REG_EMPTY && !TXD)
        else $error("transmit irq not at a start bit");
    AST_TXIRQ_PULSE: assert property (TX_IRQ |=> !TX_IRQ)
        else $error("transmit irq longer than one cycle");
    AST_DE_COVERS: assert property (!TXD |-> de_act)
        else $error("line low without driver enable");
    AST_DE_LEAD: assert property (!TXD && !seen |->
        lead >= {1'b0, div} && lead <= {div, 1'b0})
        else $error("driver enable lead outside one to two bit periods");
    AST_DE_DROP: assert property (s_drop |-> $past(TXD, 1) && $past(TXD, 2))
        else $error("driver enable dropped before the stop bit ended");
    AST_HELD: assert property (s_held |=> !de_act)
        else $error("driver enable raised while start is blocked");
    AST_TIMER: assert property (TIMER_IRQ |-> !$past(SERIAL_ENABLE))
        else $error("timer irq while serial function is on");
    AST_RX_CAUSE: assert property (RX_IRQ |-> $past(RX_BYTE_DONE) && !$past(RX_IS_ADDR))
        else $error("receive irq without a data byte");
endmodule // utx_top_chk

bind utx_top utx_top_chk chk_u
(
    .CLK(CLK), .SRST(SRST), .TX_WRITE(TX_WRITE), .TX_ENABLE(TX_ENABLE),
    .SERIAL_ENABLE(SERIAL_ENABLE), .CLEAR_TO_SEND_ENABLE(CLEAR_TO_SEND_ENABLE),
    .CTS_N(CTS_N), .DRV_EN_POLARITY(DRV_EN_POLARITY), .BAUD_HIGH(BAUD_HIGH),
    .BAUD_LOW(BAUD_LOW), .RX_BYTE_DONE(RX_BYTE_DONE), .RX_IS_ADDR(RX_IS_ADDR),
    .TXD(TXD), .DRV_EN_OUT(DRV_EN_OUT), .TX_REG_EMPTY(TX_REG_EMPTY),
    .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ), .TIMER_IRQ(TIMER_IRQ)
);

`default_nettype wire

// File: verilog/utx_brg.sv
// Baud rate generator: a down counter that pulses once per bit period.
// Assumes the divisor is held steady by software while a frame runs.
`timescale 1ns/1ns
`default_nettype none

module utx_brg
(
    input  wire logic  clk,
    input  wire logic  srst,
    utx_brg_if.gen     brg
);

    typedef struct packed {
        logic [utx_pkg::DIV_W-1:0] cnt;
        logic                      tick;
    } utx_brg_reg_t;

    utx_brg_reg_t r;
    utx_brg_reg_t next_r;
    logic [utx_pkg::DIV_W-1:0] reload;

    // ****************************************************************
    // Counter
    // ****************************************************************

    // A zero divisor would stall the line, so it runs at the fastest rate.
    always_comb
    begin
        reload = (brg.divisor == '0) ? utx_pkg::DIV_MIN : brg.divisor;
        next_r = r;
        next_r.tick = 1'b0;
        if (brg.restart)
        begin
            next_r.cnt = reload - utx_pkg::DIV_MIN;
        end
        else if (r.cnt == '0)
        begin
            next_r.cnt  = reload - utx_pkg::DIV_MIN;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.cnt = r.cnt - utx_pkg::DIV_MIN;
        end
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r.cnt  <= utx_pkg::RST_DIV_CNT;
            r.tick <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign brg.tick = r.tick;

endmodule : utx_brg

`default_nettype wire

// File: verilog/utx_top.sv
// Transmit side of an asynchronous serial port with a driver enable.
// Assumes inputs synchronous to CLK and a pulse on TX_WRITE per byte.
//
// How it works
// - Empty flag is 1 when the holding register can take a byte, else 0.
// - A written byte moves to the shift register and goes out unaided.
// - Marker bit is 1 for address bytes, 0 for data, sent with the byte.
// - Multiprocessor select makes each character nine bits with the marker.
// - Even or odd parity is available only outside multiprocessor mode.
// - Characters start only while transmit enable is set.
// - With clear-to-send enabled, a high CTS_N holds off the next character.
// - Transmitter interrupt signals the holding register is free again.
// - Filtered receive: no interrupt for address bytes, first data byte flagged.
// - Driver enable, active high by default, covers the whole frame.
// - Writing a byte to the holding register raises driver enable once a character may start.
// - Driver enable leads the start bit by one bit period plus two system clocks.
// - Driver enable drops one system clock after the last stop bit.
// - A byte waiting at frame end keeps driver enable up between characters if a character may start.
// - A polarity bit selects the active level of driver enable.
// - Transmitter and receiver have separate interrupt requests.
// - With the serial function off, the baud generator acts as a timer.
// - Bit rate comes from a divisor in high and low byte registers.
`timescale 1ns/1ns
`default_nettype none

module utx_top
(
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_WRITE,
    input  wire logic       TX_ENABLE,
    input  wire logic       SERIAL_ENABLE,
    input  wire logic       MULTIPROC_MODE_SELECT,
    input  wire logic       ADDR_MARKER_TX_BIT,
    input  wire logic       PARITY_ENABLE,
    input  wire logic       PARITY_ODD,
    input  wire logic       STOP_BITS_TWO,
    input  wire logic       CLEAR_TO_SEND_ENABLE,
    input  wire logic       CTS_N,
    input  wire logic       DRV_EN_POLARITY,
    input  wire logic [7:0] BAUD_HIGH,
    input  wire logic [7:0] BAUD_LOW,
    input  wire logic       RX_BYTE_DONE,
    input  wire logic       RX_IS_ADDR,
    input  wire logic       RX_ADDR_MATCH,
    output logic            TXD,
    output logic            DRV_EN_OUT,
    output logic            TX_REG_EMPTY,
    output logic            TX_IRQ,
    output logic            RX_IRQ,
    output logic            NEW_FRAME_FLAG,
    output logic            TIMER_IRQ
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        utx_pkg::utx_state_t              st;
        logic [utx_pkg::DATA_BITS:0]      shreg;
        logic [utx_pkg::BITCNT_W-1:0]     bitcnt;
        logic                             extra;
        logic                             stop2;
        logic [utx_pkg::DATA_BITS-1:0]    hold_data;
        logic                             hold_mark;
        logic                             empty;
        logic                             txd;
        logic                             drv_en;
        logic                             tx_irq;
        logic                             rx_irq;
        logic                             new_frame;
        logic                             frame_open;
        logic                             first_pending;
        logic                             timer_irq;
        logic                             brg_restart;
    } utx_reg_t;

    utx_reg_t r;
    utx_reg_t next_r;

    utx_brg_if brg_bus ();

    logic       tick;
    logic       load;
    logic       de_raw;
    logic [7:0] ld_data;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // A character may begin only when enabled and not held off by CTS.
    function automatic logic may_start(input logic ten, input logic cts_en,
                                       input logic cts_n, input logic ser_en);
        may_start = ten && ser_en && !(cts_en && cts_n);
    endfunction

    // Ninth bit: marker in multiprocessor mode, else parity.
    function automatic logic ninth_bit(input logic [7:0] d, input logic mp,
                                       input logic mark, input logic odd);
        if (mp)
        begin
            ninth_bit = mark;
        end
        else
        begin
            ninth_bit = (^d) ^ odd;
        end
    endfunction

    // ****************************************************************
    // Baud rate generator
    // ****************************************************************

    // The divisor is the two byte registers side by side.
    assign brg_bus.divisor = {BAUD_HIGH, BAUD_LOW};
    assign brg_bus.restart = r.brg_restart;
    assign tick            = brg_bus.tick;

    utx_brg u_brg
    (
        .clk  (CLK),
        .srst (SRST),
        .brg  (brg_bus)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Frame sequencing, holding register, and the interrupt pulses.
    always_comb
    begin
        next_r             = r;
        next_r.tx_irq      = 1'b0;
        next_r.rx_irq      = 1'b0;
        next_r.timer_irq   = 1'b0;
        next_r.brg_restart = 1'b0;
        load               = 1'b0;
        ld_data            = r.hold_data;

        case (r.st)
            // Idle line; a waiting byte opens a frame with the lead period.
            utx_pkg::ST_IDLE:
            begin
                if (!r.empty && may_start(TX_ENABLE, CLEAR_TO_SEND_ENABLE,
                                          CTS_N, SERIAL_ENABLE))
                begin
                    next_r.st          = utx_pkg::ST_LEAD;
                    next_r.brg_restart = 1'b1;
                end
            end
            // A tick left from before the restart would cut the lead short.
            utx_pkg::ST_LEAD:
            begin
                if (tick && !r.brg_restart)
                begin
                    load      = 1'b1;
                    next_r.st = utx_pkg::ST_START;
                end
            end
            utx_pkg::ST_START:
            begin
                if (tick)
                begin
                    next_r.st     = utx_pkg::ST_DATA;
                    next_r.bitcnt = '0;
                end
            end
            // Data leaves least significant bit first.
            utx_pkg::ST_DATA:
            begin
                if (tick)
                begin
                    next_r.shreg  = {1'b1, r.shreg[utx_pkg::DATA_BITS:1]};
                    next_r.bitcnt = r.bitcnt + 4'h1;
                    if (r.bitcnt == 4'(utx_pkg::DATA_BITS - 1))
                    begin
                        next_r.st = r.extra ? utx_pkg::ST_EXTRA
                                            : utx_pkg::ST_STOP;
                    end
                end
            end
            utx_pkg::ST_EXTRA:
            begin
                if (tick)
                begin
                    next_r.st = utx_pkg::ST_STOP;
                end
            end
            // After the last stop a waiting byte follows at once if a character may start.
            utx_pkg::ST_STOP:
            begin
                if (tick)
                begin
                    if (r.stop2)
                    begin
                        next_r.stop2 = 1'b0;
                    end
                    else if (!r.empty && may_start(TX_ENABLE,
                             CLEAR_TO_SEND_ENABLE, CTS_N, SERIAL_ENABLE))
                    begin
                        load      = 1'b1;
                        next_r.st = utx_pkg::ST_START;
                    end
                    else
                    begin
                        next_r.st = utx_pkg::ST_TAIL;
                    end
                end
            end
            // One clock of tail with the line idle, then release.
            utx_pkg::ST_TAIL:
            begin
                next_r.st = utx_pkg::ST_IDLE;
            end
            default:
            begin
                next_r.st = utx_pkg::ST_IDLE;
            end
        endcase

        // Loading the shift register frees the holding register.
        if (load)
        begin
            next_r.shreg = {ninth_bit(ld_data, MULTIPROC_MODE_SELECT,
                                      r.hold_mark, PARITY_ODD), ld_data};
            next_r.extra = MULTIPROC_MODE_SELECT || PARITY_ENABLE;
            next_r.stop2 = STOP_BITS_TWO;
            next_r.empty = 1'b1;
            next_r.tx_irq = 1'b1;
        end

        // A write while full is dropped unless a load frees the register that cycle; software polls the empty flag.
        if (TX_WRITE && (r.empty || load))
        begin
            next_r.hold_data = TX_DATA;
            next_r.hold_mark = ADDR_MARKER_TX_BIT;
            next_r.empty     = 1'b0;
        end

        // Line level follows the state being entered.
        case (next_r.st)
            utx_pkg::ST_START: next_r.txd = 1'b0;
            utx_pkg::ST_DATA:  next_r.txd = next_r.shreg[0];
            // After eight shifts the marker or parity bit sits at the bottom.
            utx_pkg::ST_EXTRA: next_r.txd = next_r.shreg[0];
            default:           next_r.txd = 1'b1;
        endcase

        // Driver enable covers lead, frame and one tail clock.
        de_raw = (next_r.st != utx_pkg::ST_IDLE);
        next_r.drv_en = de_raw ^ DRV_EN_POLARITY;

        // Address filtering: addresses open or close a frame silently.
        if (RX_BYTE_DONE)
        begin
            if (RX_IS_ADDR)
            begin
                next_r.frame_open    = RX_ADDR_MATCH;
                next_r.first_pending = RX_ADDR_MATCH;
            end
            else if (r.frame_open)
            begin
                next_r.rx_irq        = 1'b1;
                next_r.new_frame     = r.first_pending;
                next_r.first_pending = 1'b0;
            end
        end

        // With the serial function off the generator is a plain timer.
        if (!SERIAL_ENABLE && tick)
        begin
            next_r.timer_irq = 1'b1;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // All state updates on every edge; reset forces an idle line.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            r.st            <= utx_pkg::ST_IDLE;
            r.shreg         <= '1;
            r.bitcnt        <= '0;
            r.extra         <= 1'b0;
            r.stop2         <= 1'b0;
            r.hold_data     <= '0;
            r.hold_mark     <= 1'b0;
            r.empty         <= utx_pkg::RST_EMPTY;
            r.txd           <= utx_pkg::RST_TXD;
            r.drv_en        <= utx_pkg::RST_DRV_EN;
            r.tx_irq        <= 1'b0;
            r.rx_irq        <= 1'b0;
            r.new_frame     <= 1'b0;
            r.frame_open    <= 1'b0;
            r.first_pending <= 1'b0;
            r.timer_irq     <= 1'b0;
            r.brg_restart   <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Every output is a flip-flop of the state record.
    assign TXD            = r.txd;
    assign DRV_EN_OUT     = r.drv_en;
    assign TX_REG_EMPTY   = r.empty;
    assign TX_IRQ         = r.tx_irq;
    assign RX_IRQ         = r.rx_irq;
    assign NEW_FRAME_FLAG = r.new_frame;
    assign TIMER_IRQ      = r.timer_irq;

endmodule : utx_top

`default_nettype wire
